// ===== logic/wfh_map.svh
// Constants of the waveform capture and harmonic feed block.
// Assumes a single 50 MHz clock and a sample strobe from the front end.
`ifndef WFH_MAP_SVH
`define WFH_MAP_SVH

// ---------------------------------------------------------------
// Channel map
// ---------------------------------------------------------------
`define WFH_CHANNELS 18
`define WFH_CHAN_LAST 5'h11
`define WFH_CHAN_RESET 5'h00

// ---------------------------------------------------------------
// Buffers
// ---------------------------------------------------------------
`define WFH_DISP_LEN 100
`define WFH_DISP_LAST 10'h063
`define WFH_ANA_LEN 1024
`define WFH_ANA_LAST 10'h3FF
`define WFH_SMP_RATE_HZ 4096

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WFH_CLK_HZ 50000000
`define WFH_REFRESH_MS 500
`define WFH_REFRESH_CYCLES (`WFH_REFRESH_MS * (`WFH_CLK_HZ / 1000))

// ---------------------------------------------------------------
// Harmonic limits, amplitudes in 0.1 percent units
// ---------------------------------------------------------------
`define WFH_MAX_HZ 16'h0708
`define WFH_MAX_ORDER 5'h1F
`define WFH_MIN_ORDER 5'h02
`define WFH_GRAPH_MIN 10'h014

`endif

// ===== logic/wfh_pkg.sv
// Types of the waveform capture and harmonic feed block.
// Assumes nothing beyond the constants header.
package wfh_pkg;
    typedef logic [12:0] wfh_sample_t;
    typedef logic [4:0] wfh_chan_t;
    typedef logic [9:0] wfh_amp_t;
    typedef enum logic [0:0] {WFH_IDLE, WFH_CAPT} wfh_state_t;
endpackage

// ===== logic/wfh_mem_if.sv
// Carrier between the capture logic and a sample memory.
// Assumes one writer and one reader, both on mclk.
`timescale 1ns/1ps
interface wfh_mem_if #(parameter int W = 13, parameter int AW = 8);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [W-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [W-1:0] rd_data;
    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
        input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
        output rd_data);
endinterface

// ===== logic/wfh_sample_mem.sv
// Two-bank sample memory with a registered read port.
// Assumes the owner keeps writes and reads in separate banks.
`timescale 1ns/1ps
module wfh_sample_mem #(
    parameter int W = 13,
    parameter int AW = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    wfh_mem_if.store port
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (port.wr_en) begin
            mem[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            port.rd_data <= '0;
        end else begin
            port.rd_data <= mem[port.rd_addr];
        end
    end
endmodule // wfh_sample_mem

// ===== logic/wfh_capture.sv
// Waveform capture, channel selection, autoscale and harmonic filtering.
// Assumes smp_valid pulses once per sample at 4096 Hz on mclk for the
// channel named by sel_chan; buttons are raw panel pins.
`timescale 1ns/1ps
`include "wfh_map.svh"
module wfh_capture import wfh_pkg::*; #(
    parameter int REFRESH_CYCLES = `WFH_REFRESH_CYCLES,
    parameter int DISP_BITS = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic btn_next,
    input wire logic btn_prev,
    input wire logic smp_valid,
    input wire wfh_sample_t smp_data,
    input wire logic [10:0] fund_hz,
    input wire logic rd_req,
    input wire logic [6:0] rd_index,
    input wire logic ana_rd_req,
    input wire logic [9:0] ana_rd_addr,
    input wire logic harm_valid,
    input wire logic [4:0] harm_order,
    input wire wfh_amp_t harm_amp,
    output wfh_chan_t sel_chan,
    output wfh_sample_t rd_data,
    output logic rd_valid,
    output wfh_sample_t ana_rd_data,
    output logic ana_rd_valid,
    output logic ana_start,
    output logic capture_busy,
    output logic [3:0] disp_shift,
    output logic [4:0] max_order,
    output logic list_valid,
    output logic [4:0] list_order,
    output wfh_amp_t list_amp,
    output logic graph_show
);
    localparam int TW = $clog2(REFRESH_CYCLES);

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic logic [12:0] mag(input wfh_sample_t s);
        mag = s[12] ? 13'(-s) : s;
    endfunction

    function automatic logic [3:0] scale_of(input logic [12:0] pk);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 13; i++) begin
            if ((pk >> i) >= 13'(1 << (DISP_BITS - 1))) begin
                s = 4'(i + 1);
            end
        end
        scale_of = s;
    endfunction

    function automatic logic [4:0] order_limit(input logic [10:0] f);
        logic [4:0] m;
        m = `WFH_MAX_ORDER;
        if (f != 11'h000) begin
            m = 5'h00;
            for (int o = 1; o <= 31; o++) begin
                if (16'(o) * 16'(f) <= `WFH_MAX_HZ) begin
                    m = 5'(o);
                end
            end
        end
        order_limit = m;
    endfunction

    // ---------------------------------------------------------------
    // Button synchronisers and channel stepping
    // ---------------------------------------------------------------
    logic [2:0] nx_sync;
    logic [2:0] pv_sync;
    wire nx_edge = nx_sync[1] & ~nx_sync[2];
    wire pv_edge = pv_sync[1] & ~pv_sync[2];
    wire chan_step = nx_edge ^ pv_edge;
    wire wfh_chan_t next_chan = nx_edge ?
        ((sel_chan == `WFH_CHAN_LAST) ? 5'h00 : 5'(sel_chan + 5'h01)) :
        ((sel_chan == 5'h00) ? `WFH_CHAN_LAST : 5'(sel_chan - 5'h01));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nx_sync <= 3'h0;
            pv_sync <= 3'h0;
            sel_chan <= `WFH_CHAN_RESET;
        end else begin
            nx_sync <= {nx_sync[1:0], btn_next};
            pv_sync <= {pv_sync[1:0], btn_prev};
            if (chan_step) begin
                sel_chan <= next_chan;
            end
        end
    end

    // ---------------------------------------------------------------
    // Half-second refresh tick
    // ---------------------------------------------------------------
    logic [TW-1:0] tmr;
    wire tick = (tmr == TW'(REFRESH_CYCLES - 1));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tmr <= '0;
        end else begin
            tmr <= tick ? '0 : TW'(tmr + 1'b1);
        end
    end

    // ---------------------------------------------------------------
    // Capture sequencer
    // ---------------------------------------------------------------
    wfh_state_t state;
    logic [9:0] cnt;
    logic bank_d;
    logic bank_a;
    logic [12:0] peak;
    wfh_mem_if #(.W(13), .AW(8)) dmem ();
    wfh_mem_if #(.W(13), .AW(11)) amem ();

    wire take = (state == WFH_CAPT) && smp_valid;
    wire in_disp = (cnt <= `WFH_DISP_LAST);
    wire disp_done = take && (cnt == `WFH_DISP_LAST);
    wire ana_done = take && (cnt == `WFH_ANA_LAST);
    wire [12:0] smp_mag = mag(smp_data);
    wire [12:0] next_peak = (smp_mag > peak) ? smp_mag : peak;

    // Writes go to the idle bank only
    assign dmem.wr_en = take && in_disp;
    assign dmem.wr_addr = {~bank_d, cnt[6:0]};
    assign dmem.wr_data = smp_data;
    assign dmem.rd_addr = {bank_d, rd_index};
    assign amem.wr_en = take;
    assign amem.wr_addr = {~bank_a, cnt};
    assign amem.wr_data = smp_data;
    assign amem.rd_addr = {bank_a, ana_rd_addr};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= WFH_IDLE;
            cnt <= 10'h000;
            bank_d <= 1'b0;
            bank_a <= 1'b0;
            peak <= 13'h0000;
            disp_shift <= 4'h0;
            ana_start <= 1'b0;
            capture_busy <= 1'b0;
        end else begin
            ana_start <= 1'b0;
            case (state)
                WFH_IDLE: begin
                    if (tick && !chan_step) begin
                        state <= WFH_CAPT;
                        capture_busy <= 1'b1;
                        cnt <= 10'h000;
                        peak <= 13'h0000;
                    end
                end
                WFH_CAPT: begin
                    if (chan_step) begin
                        // Mixed-channel snapshot is dropped
                        state <= WFH_IDLE;
                        capture_busy <= 1'b0;
                    end else if (take) begin
                        cnt <= 10'(cnt + 10'h001);
                        if (in_disp) begin
                            peak <= next_peak;
                        end
                        if (disp_done) begin
                            bank_d <= ~bank_d;
                            disp_shift <= scale_of(next_peak);
                        end
                        if (ana_done) begin
                            bank_a <= ~bank_a;
                            ana_start <= 1'b1;
                            state <= WFH_IDLE;
                            capture_busy <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= WFH_IDLE;
                end
            endcase
        end
    end

    wfh_sample_mem #(.W(13), .AW(8)) u_disp_mem (
        .mclk(mclk),
        .arst_n(arst_n),
        .port(dmem)
    );

    wfh_sample_mem #(.W(13), .AW(11)) u_ana_mem (
        .mclk(mclk),
        .arst_n(arst_n),
        .port(amem)
    );

    // ---------------------------------------------------------------
    // Read ports, two cycles from request to data
    // ---------------------------------------------------------------
    logic rd_p1;
    logic rd_ok_p1;
    logic ana_p1;
    wire rd_in_range = ({3'h0, rd_index} <= `WFH_DISP_LAST);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_p1 <= 1'b0;
            rd_ok_p1 <= 1'b0;
            ana_p1 <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 13'h0000;
            ana_rd_valid <= 1'b0;
            ana_rd_data <= 13'h0000;
        end else begin
            rd_p1 <= rd_req;
            rd_ok_p1 <= rd_in_range;
            ana_p1 <= ana_rd_req;
            rd_valid <= rd_p1;
            if (rd_p1) begin
                rd_data <= rd_ok_p1 ? dmem.rd_data : 13'h0000;
            end
            ana_rd_valid <= ana_p1;
            if (ana_p1) begin
                ana_rd_data <= amem.rd_data;
            end
        end
    end

    // ---------------------------------------------------------------
    // Harmonic result filter
    // ---------------------------------------------------------------
    wire [4:0] next_max = order_limit(fund_hz);
    wire harm_keep = harm_valid && (harm_order >= `WFH_MIN_ORDER) && (harm_order <= next_max);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            max_order <= `WFH_MAX_ORDER;
            list_valid <= 1'b0;
            list_order <= 5'h00;
            list_amp <= 10'h000;
            graph_show <= 1'b0;
        end else begin
            max_order <= next_max;
            list_valid <= harm_keep;
            if (harm_keep) begin
                list_order <= harm_order;
                list_amp <= harm_amp;
                graph_show <= (harm_amp > `WFH_GRAPH_MIN);
            end
        end
    end
endmodule // wfh_capture

// ===== tb/wfh_capture_monitor.sv
// Checker of the capture block's port timing.
// Assumes it is bound to wfh_capture and sees its ports by name.
`timescale 1ns/1ps
module wfh_capture_monitor import wfh_pkg::*; (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic rd_req,
    input wire logic rd_valid,
    input wire logic ana_rd_req,
    input wire logic ana_rd_valid,
    input wire logic ana_start,
    input wire logic capture_busy,
    input wire wfh_chan_t sel_chan,
    input wire logic [10:0] fund_hz,
    input wire logic [4:0] max_order,
    input wire logic harm_valid,
    input wire logic [4:0] harm_order,
    input wire wfh_amp_t harm_amp,
    input wire logic list_valid,
    input wire wfh_amp_t list_amp,
    input wire logic graph_show,
    input wire logic [3:0] disp_shift
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ------------------------------
    // Assertions
    // ------------------------------
    rd_answer_a: assert property (rd_req |-> ##2 rd_valid)
        else $error("display read not answered");
    rd_cause_a: assert property (rd_valid |-> $past(rd_req, 2))
        else $error("display answer without request");
    ana_answer_a: assert property (ana_rd_req |-> ##2 ana_rd_valid)
        else $error("analysis read not answered");
    start_end_a: assert property (ana_start |-> $fell(capture_busy))
        else $error("analysis start without capture end");
    start_pulse_a: assert property (ana_start |=> !ana_start)
        else $error("analysis start too long");
    chan_range_a: assert property (sel_chan <= 5'h11)
        else $error("channel out of range");
    order_cap_a: assert property ($past(fund_hz) == 11'h000 |-> max_order == 5'h1F)
        else $error("order limit wrong");
    list_kept_a: assert property (list_valid |-> $past(harm_valid) && $past(harm_order) >= 5'h02)
        else $error("listed result not allowed");
    graph_thr_a: assert property (list_valid |-> graph_show == (list_amp > 10'h014))
        else $error("graph flag wrong");
    list_amp_a: assert property (list_valid |-> list_amp == $past(harm_amp))
        else $error("listed amplitude wrong");
    shift_hold_a: assert property (!capture_busy && !$past(capture_busy) |-> $stable(disp_shift))
        else $error("scale changed while idle");
    cover property (ana_start);
    cover property (list_valid && graph_show);
    cover property (rd_valid);
endmodule // wfh_capture_monitor

// ===== tb/wfh_front_model.sv
// Sampling front end: a strobe every other cycle, sample k = 4*k.
// Assumes capture_busy from the block frames the sample count.
`timescale 1ns/1ps
module wfh_front_model import wfh_pkg::*; (
    input wire logic mclk,
    input wire logic capture_busy,
    output logic smp_valid,
    output wfh_sample_t smp_data
);
    logic [9:0] k = 10'h000;
    logic phase = 1'b0;
    logic busy_q = 1'b0;
    assign smp_valid = phase;
    assign smp_data = {1'b0, k, 2'b00};
    // Advance only after a strobe the block really took
    always @(negedge mclk) begin
        if (!capture_busy) k <= 10'h000;
        else if (phase && busy_q) k <= k + 10'h001;
        busy_q <= capture_busy;
        phase <= !phase;
    end
endmodule // wfh_front_model

// ===== tb/wfh_tb.sv
// Self-checking bench of the capture block.
// Assumes the monitor and front model files are compiled first.
`timescale 1ns/1ps
module tb import wfh_pkg::*;;
    localparam int REFR = 3000;
    logic mclk = 0, arst_n = 0, btn_next = 0, btn_prev = 0;
    logic rd_req = 0, ana_rd_req = 0, harm_valid = 0;
    logic [10:0] fund_hz = 0;
    logic [6:0] rd_index = 0;
    logic [9:0] ana_rd_addr = 0;
    logic [4:0] harm_order = 0, max_order, list_order;
    wfh_amp_t harm_amp = 0, list_amp;
    logic smp_valid, rd_valid, ana_rd_valid, ana_start, capture_busy;
    logic list_valid, graph_show;
    logic [3:0] disp_shift;
    wfh_sample_t smp_data, rd_data, ana_rd_data;
    wfh_chan_t sel_chan;
    int miscompares = 0, total_checks = 0, cyc = 0, t0, t1;
    always #10 mclk = ~mclk;
    always @(posedge mclk) cyc++;
    wfh_capture #(.REFRESH_CYCLES(REFR)) wfh_capture_inst (.*);
    wfh_front_model wfh_front_model_inst (.mclk(mclk), .capture_busy(capture_busy),
        .smp_valid(smp_valid), .smp_data(smp_data));
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task press(input bit nxt);
        if (nxt) btn_next = 1;
        else btn_prev = 1;
        tick(5);
        btn_next = 0;
        btn_prev = 0;
        tick(5);
    endtask
    task harm(input logic [4:0] o, input wfh_amp_t a);
        harm_valid = 1;
        harm_order = o;
        harm_amp = a;
        tick(1);
        harm_valid = 0;
    endtask
    task rd(input bit a, input logic [9:0] i, input logic [12:0] e);
        if (a) begin
            ana_rd_req = 1;
            ana_rd_addr = i;
        end else begin
            rd_req = 1;
            rd_index = i[6:0];
        end
        tick(1);
        rd_req = 0;
        ana_rd_req = 0;
        tick(1);
        check(a ? ana_rd_valid : rd_valid, 1);
        check(a ? ana_rd_data : rd_data, e);
        tick(1);
        check(a ? ana_rd_valid : rd_valid, 0);
    endtask
    task wait_start(output int t);
        int n;
        n = 0;
        while (ana_start !== 1'b1 && n < 8000) begin
            tick(1);
            n++;
        end
        if (n >= 8000) begin
            miscompares++;
            tally_and_finish;
        end
        t = cyc;
        tick(1);
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    task test_reset;
        check(sel_chan, 0);
        check(max_order, 31);
        check(capture_busy, 0);
        $display("reset test done");
    endtask
    task test_buttons;
        for (int i = 1; i <= 18; i++) begin
            press(1);
            check(sel_chan, i % 18);
        end
        press(0);
        check(sel_chan, 17);
        press(1);
        check(sel_chan, 0);
        $display("button test done");
    endtask
    task test_harm;
        fund_hz = 60;
        tick(2);
        check(max_order, 30);
        harm(3, 25);
        check(list_valid, 1);
        check(list_amp, 25);
        check(graph_show, 1);
        harm(30, 20);
        check(list_order, 30);
        check(graph_show, 0);
        harm(31, 5);
        check(list_valid, 0);
        harm(1, 50);
        check(list_valid, 0);
        check(list_order, 30);
        fund_hz = 400;
        tick(2);
        check(max_order, 4);
        fund_hz = 0;
        tick(2);
        $display("harmonic test done");
    endtask
    task test_capture;
        wait_start(t0);
        check(capture_busy, 0);
        check(disp_shift, 2);
        rd(0, 0, 0);
        rd(0, 99, 13'h018C);
        rd(0, 100, 0);
        rd(1, 512, 13'h0800);
        rd(1, 1023, 13'h0FFC);
        wait_start(t1);
        check(t1 - t0, REFR);
        $display("capture test done");
    endtask
    task test_abort;
        int n;
        n = 0;
        while (capture_busy !== 1'b1 && n < 4000) begin
            tick(1);
            n++;
        end
        if (n >= 4000) begin
            miscompares++;
            tally_and_finish;
        end
        press(1);
        check(capture_busy, 0);
        check(ana_start, 0);
        check(sel_chan, 1);
        rd(0, 99, 13'h018C);
        rd(1, 1023, 13'h0FFC);
        btn_next = 1;
        btn_prev = 1;
        tick(5);
        btn_next = 0;
        btn_prev = 0;
        tick(5);
        check(sel_chan, 1);
        $display("abort test done");
    endtask
    initial begin
        tick(4);
        arst_n = 1;
        tick(1);
        test_reset;
        test_buttons;
        test_harm;
        test_capture;
        test_abort;
        tally_and_finish;
    end
endmodule // tb
bind wfh_capture wfh_capture_monitor wfh_capture_monitor_inst (
    .mclk(mclk),
    .arst_n(arst_n),
    .rd_req(rd_req),
    .rd_valid(rd_valid),
    .ana_rd_req(ana_rd_req),
    .ana_rd_valid(ana_rd_valid),
    .ana_start(ana_start),
    .capture_busy(capture_busy),
    .sel_chan(sel_chan),
    .fund_hz(fund_hz),
    .max_order(max_order),
    .harm_valid(harm_valid),
    .harm_order(harm_order),
    .harm_amp(harm_amp),
    .list_valid(list_valid),
    .list_amp(list_amp),
    .graph_show(graph_show),
    .disp_shift(disp_shift)
);
